// >>> logic/tprf_defs.vh
// Purpose: Shared constants of the test port, reset and flag block
// Assumes: Included by the top-level design file of the block only
// Notes: Definitions only
`ifndef TPRF_DEFS_VH
`define TPRF_DEFS_VH

// ==========================================================
// Reset and boot
`define TPRF_RESET_VECTOR 24'hFFFF00
`define TPRF_PC_W 24
`define TPRF_ST_W 16
`define TPRF_ST1_RESET 16'h2000
`define TPRF_FLAG_BIT 13

// ==========================================================
// Synchroniser slots
`define TPRF_SY_TCK 0
`define TPRF_SY_TMS 1
`define TPRF_SY_TDI 2
`define TPRF_SY_TRST 3
`define TPRF_SY_EMULATION_PIN_ZERO 4
`define TPRF_SY_RSTN 5
`define TPRF_SY_W 6

// ==========================================================
// Test-port controller states
`define TPRF_TAP_W 4
`define TPRF_S_TLR 4'h0
`define TPRF_S_RTI 4'h1
`define TPRF_S_SEL_DR 4'h2
`define TPRF_S_CAP_DR 4'h3
`define TPRF_S_SHF_DR 4'h4
`define TPRF_S_EX1_DR 4'h5
`define TPRF_S_PAU_DR 4'h6
`define TPRF_S_EX2_DR 4'h7
`define TPRF_S_UPD_DR 4'h8
`define TPRF_S_SEL_IR 4'h9
`define TPRF_S_CAP_IR 4'hA
`define TPRF_S_SHF_IR 4'hB
`define TPRF_S_EX1_IR 4'hC
`define TPRF_S_PAU_IR 4'hD
`define TPRF_S_EX2_IR 4'hE
`define TPRF_S_UPD_IR 4'hF

// Instruction capture pattern, low two bits 01
`define TPRF_IR_CAPTURE 2'h1

`endif

// >>> logic/tprf_sync.v
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to mclk_i
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module tprf_sync #(
  parameter WIDTH = 6
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge mclk_i) begin
        if (rst_i) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= async_i[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_ff;

endmodule

// >>> logic/tprf_shreg.v
// Purpose: Scan register with capture, serial shift and update stage
// Assumes: Strobes are one-cycle pulses on mclk_i
// Notes: Shifts toward the low bit; serial output is bit 0
`timescale 1ns/1ps
module tprf_shreg #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  input wire mclk_i,
  input wire rst_i,
  input wire clear_i,
  input wire capture_i,
  input wire [WIDTH-1:0] capture_data_i,
  input wire shift_i,
  input wire serial_i,
  input wire update_i,
  output wire serial_o,
  output wire [WIDTH-1:0] update_o
);

  reg [WIDTH-1:0] shift_ff;
  reg [WIDTH-1:0] upd_ff;

  always @(posedge mclk_i) begin
    if (rst_i || clear_i) begin
      shift_ff <= RESET_VAL;
      upd_ff <= RESET_VAL;
    end else begin
      if (capture_i) begin
        shift_ff <= capture_data_i;
      end else if (shift_i) begin
        shift_ff <= {serial_i, shift_ff[WIDTH-1:1]};
      end
      if (update_i) begin
        upd_ff <= shift_ff;
      end
    end
  end

  assign serial_o = shift_ff[0];
  assign update_o = upd_ff;

endmodule

// >>> logic/tprf_top.v
// Purpose: Test port, device reset sequencing and external flag output
// Assumes: Test clock far slower than mclk_i; instruction strobes on mclk_i
// Notes: Pins are synchronised before use
// What this block does
// R01 - Bit-set instruction drives flag pin high
// R02 - Bit-clear or status bit 13 written 0 drives low
// R03 - Flag pin high throughout reset
// R04 - Reset halts core, loads vector, resets status
// R05 - Release starts at vector, branches to loader
// R06 - Reset pull-up forced on during reset
// R07 - Mode select sampled on rising test clock
// R08 - Data input shifted on rising test clock
// R09 - Data output changes on falling test clock
// R10 - Data output high-impedance unless shifting
// R11 - Test reset low: functional, test pins ignored
// R12 - Test reset rise latches emulation pin zero
// R13 - Flag change visible cycle after instruction
`timescale 1ns/1ps
`include "tprf_defs.vh"
module tprf_top #(
  parameter IR_W = 4,
  parameter DR_W = 8,
  parameter [`TPRF_PC_W-1:0] BOOT_ENTRY = 24'h000000
) (
  input wire mclk_i,
  input wire rst_i,
  input wire reset_n_i,
  input wire bit_set_instruction_i,
  input wire bit_clear_instruction_i,
  input wire cpu_status_word_one_wr_i,
  input wire [`TPRF_ST_W-1:0] cpu_status_word_one_wdata_i,
  input wire pull_inhibit_register_two_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  input wire test_reset_i,
  input wire emulation_pin_zero_i,
  input wire [DR_W-1:0] scan_capture_i,
  output wire external_flag_output_o,
  output wire [`TPRF_ST_W-1:0] cpu_status_word_one_o,
  output wire cpu_halt_o,
  output wire [`TPRF_PC_W-1:0] pc_o,
  output wire reset_pullup_en_o,
  output wire tdo_o,
  output wire tdo_oe_n_o,
  output wire scan_mode_o,
  output wire emu_port_sel_o,
  output wire [DR_W-1:0] scan_update_o,
  output wire [IR_W-1:0] instr_o
);

  // ==========================================================
  // Pin synchronisers
  wire [`TPRF_SY_W-1:0] sy;

  tprf_sync #(
    .WIDTH(`TPRF_SY_W)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({reset_n_i, emulation_pin_zero_i, test_reset_i, tdi_i, tms_i, tck_i}),
    .sync_o(sy)
  );

  wire tck_s = sy[`TPRF_SY_TCK];
  wire tms_s = sy[`TPRF_SY_TMS];
  wire tdi_s = sy[`TPRF_SY_TDI];
  wire trst_s = sy[`TPRF_SY_TRST];
  wire emulation_pin_zero_s = sy[`TPRF_SY_EMULATION_PIN_ZERO];
  wire rstn_s = sy[`TPRF_SY_RSTN];

  // ==========================================================
  // Device reset and boot sequence
  wire dev_rst = rst_i | ~rstn_s;
  reg [`TPRF_PC_W-1:0] pc_ff;
  reg [`TPRF_PC_W-1:0] nxt_pc;
  reg halt_ff;
  reg boot_ff;
  reg pullup_ff;

  always @* begin
    nxt_pc = pc_ff;
    if (dev_rst) begin
      nxt_pc = `TPRF_RESET_VECTOR; // [R04]
    end else if (!boot_ff && !halt_ff) begin
      // First running cycle sits at the vector, then branches
      nxt_pc = BOOT_ENTRY; // [R05]
    end
  end

  always @(posedge mclk_i) begin
    if (dev_rst) begin
      pc_ff <= `TPRF_RESET_VECTOR; // [R04]
      halt_ff <= 1'b1; // [R04]
      boot_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      halt_ff <= 1'b0; // [R05]
      boot_ff <= ~halt_ff;
    end
  end

  // Pull-up on when not inhibited or when reset is held
  always @(posedge mclk_i) begin
    if (rst_i) begin
      pullup_ff <= 1'b1;
    end else begin
      pullup_ff <= ~pull_inhibit_register_two_i | ~rstn_s; // [R06]
    end
  end

  // ==========================================================
  // External flag and status word
  reg flag_ff;
  reg nxt_flag;
  reg [`TPRF_ST_W-1:0] st1_ff;
  wire st1_clr = cpu_status_word_one_wr_i & ~cpu_status_word_one_wdata_i[`TPRF_FLAG_BIT];

  always @* begin
    nxt_flag = flag_ff;
    if (bit_set_instruction_i) begin
      nxt_flag = 1'b1; // [R01]
    end else if (bit_clear_instruction_i || st1_clr) begin
      nxt_flag = 1'b0; // [R02]
    end
  end

  always @(posedge mclk_i) begin
    if (dev_rst) begin
      flag_ff <= 1'b1; // [R03]
      st1_ff <= `TPRF_ST1_RESET; // [R04]
    end else begin
      flag_ff <= nxt_flag; // [R13]
      if (cpu_status_word_one_wr_i) begin
        st1_ff <= cpu_status_word_one_wdata_i;
      end
    end
  end

  // ==========================================================
  // Test reset and port routing
  reg trst_d_ff;
  reg emu_sel_ff;
  reg tck_d_ff;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      trst_d_ff <= 1'b0;
      emu_sel_ff <= 1'b0;
      tck_d_ff <= 1'b0;
    end else begin
      trst_d_ff <= trst_s;
      tck_d_ff <= tck_s;
      if (trst_s && !trst_d_ff) begin
        emu_sel_ff <= emulation_pin_zero_s; // [R12]
      end
    end
  end

  // Boundary-scan port live only under test reset and latched zero
  wire bs_en = trst_s & trst_d_ff & ~emu_sel_ff; // [R11] [R12]
  wire tck_rise = bs_en & tck_s & ~tck_d_ff; // [R07]
  wire tck_fall = bs_en & ~tck_s & tck_d_ff; // [R09]

  // ==========================================================
  // Test-port controller
  reg [`TPRF_TAP_W-1:0] tap_ff;
  reg [`TPRF_TAP_W-1:0] nxt_tap;

  always @* begin
    case (tap_ff)
      `TPRF_S_TLR: nxt_tap = tms_s ? `TPRF_S_TLR : `TPRF_S_RTI;
      `TPRF_S_RTI: nxt_tap = tms_s ? `TPRF_S_SEL_DR : `TPRF_S_RTI;
      `TPRF_S_SEL_DR: nxt_tap = tms_s ? `TPRF_S_SEL_IR : `TPRF_S_CAP_DR;
      `TPRF_S_CAP_DR: nxt_tap = tms_s ? `TPRF_S_EX1_DR : `TPRF_S_SHF_DR;
      `TPRF_S_SHF_DR: nxt_tap = tms_s ? `TPRF_S_EX1_DR : `TPRF_S_SHF_DR;
      `TPRF_S_EX1_DR: nxt_tap = tms_s ? `TPRF_S_UPD_DR : `TPRF_S_PAU_DR;
      `TPRF_S_PAU_DR: nxt_tap = tms_s ? `TPRF_S_EX2_DR : `TPRF_S_PAU_DR;
      `TPRF_S_EX2_DR: nxt_tap = tms_s ? `TPRF_S_UPD_DR : `TPRF_S_SHF_DR;
      `TPRF_S_UPD_DR: nxt_tap = tms_s ? `TPRF_S_SEL_DR : `TPRF_S_RTI;
      `TPRF_S_SEL_IR: nxt_tap = tms_s ? `TPRF_S_TLR : `TPRF_S_CAP_IR;
      `TPRF_S_CAP_IR: nxt_tap = tms_s ? `TPRF_S_EX1_IR : `TPRF_S_SHF_IR;
      `TPRF_S_SHF_IR: nxt_tap = tms_s ? `TPRF_S_EX1_IR : `TPRF_S_SHF_IR;
      `TPRF_S_EX1_IR: nxt_tap = tms_s ? `TPRF_S_UPD_IR : `TPRF_S_PAU_IR;
      `TPRF_S_PAU_IR: nxt_tap = tms_s ? `TPRF_S_EX2_IR : `TPRF_S_PAU_IR;
      `TPRF_S_EX2_IR: nxt_tap = tms_s ? `TPRF_S_UPD_IR : `TPRF_S_SHF_IR;
      `TPRF_S_UPD_IR: nxt_tap = tms_s ? `TPRF_S_SEL_DR : `TPRF_S_RTI;
      default: nxt_tap = `TPRF_S_TLR;
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i || !bs_en) begin
      tap_ff <= `TPRF_S_TLR; // [R11]
    end else if (tck_rise) begin
      tap_ff <= nxt_tap; // [R07]
    end
  end

  // Decode of one controller state
  function tap_at;
    input [`TPRF_TAP_W-1:0] st;
    input [`TPRF_TAP_W-1:0] want;
    begin
      tap_at = (st == want);
    end
  endfunction

  // Strobes on a rising test clock edge, plus shift and reset state levels
  wire in_shf_dr = tap_at(tap_ff, `TPRF_S_SHF_DR);
  wire in_shf_ir = tap_at(tap_ff, `TPRF_S_SHF_IR);
  wire cap_dr = tck_rise & tap_at(tap_ff, `TPRF_S_CAP_DR);
  wire cap_ir = tck_rise & tap_at(tap_ff, `TPRF_S_CAP_IR);
  wire upd_dr = tck_rise & tap_at(tap_ff, `TPRF_S_UPD_DR);
  wire upd_ir = tck_rise & tap_at(tap_ff, `TPRF_S_UPD_IR);
  wire shf_dr = tck_rise & in_shf_dr;
  wire shf_ir = tck_rise & in_shf_ir;
  wire tlr = tap_at(tap_ff, `TPRF_S_TLR);

  // ==========================================================
  // Instruction and data registers
  wire ir_so;
  wire [IR_W-1:0] ir_q;
  wire dr_so;
  wire [DR_W-1:0] dr_q;
  reg byp_ff;
  wire sel_bypass = &ir_q;

  tprf_shreg #(
    .WIDTH(IR_W),
    .RESET_VAL({IR_W{1'b1}})
  ) u_ir (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(tlr),
    .capture_i(cap_ir),
    .capture_data_i({{(IR_W-2){1'b0}}, `TPRF_IR_CAPTURE}),
    .shift_i(shf_ir), // [R08]
    .serial_i(tdi_s),
    .update_i(upd_ir),
    .serial_o(ir_so),
    .update_o(ir_q)
  );

  tprf_shreg #(
    .WIDTH(DR_W),
    .RESET_VAL({DR_W{1'b0}})
  ) u_dr (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(1'b0),
    .capture_i(cap_dr & ~sel_bypass),
    .capture_data_i(scan_capture_i),
    .shift_i(shf_dr & ~sel_bypass), // [R08]
    .serial_i(tdi_s),
    .update_i(upd_dr & ~sel_bypass),
    .serial_o(dr_so),
    .update_o(dr_q)
  );

  always @(posedge mclk_i) begin
    if (rst_i || cap_dr) begin
      byp_ff <= 1'b0;
    end else if (shf_dr && sel_bypass) begin
      byp_ff <= tdi_s; // [R08]
    end
  end

  // ==========================================================
  // Serial output on falling test clock
  reg tdo_ff;
  reg tdo_oe_n_ff;

  always @(posedge mclk_i) begin
    if (rst_i || !bs_en) begin
      tdo_ff <= 1'b0;
      tdo_oe_n_ff <= 1'b1; // [R10]
    end else if (tck_fall) begin
      if (in_shf_ir) begin
        tdo_ff <= ir_so; // [R09]
        tdo_oe_n_ff <= 1'b0;
      end else if (in_shf_dr) begin
        tdo_ff <= sel_bypass ? byp_ff : dr_so; // [R09]
        tdo_oe_n_ff <= 1'b0;
      end else begin
        tdo_oe_n_ff <= 1'b1; // [R10]
      end
    end
  end

  // ==========================================================
  // Outputs
  assign external_flag_output_o = flag_ff;
  assign cpu_status_word_one_o = st1_ff;
  assign cpu_halt_o = halt_ff;
  assign pc_o = pc_ff;
  assign reset_pullup_en_o = pullup_ff;
  assign tdo_o = tdo_ff;
  assign tdo_oe_n_o = tdo_oe_n_ff;
  assign scan_mode_o = bs_en;
  assign emu_port_sel_o = emu_sel_ff;
  assign scan_update_o = dr_q;
  assign instr_o = ir_q;

endmodule

// >>> tb/tprf_top_asserts.sv
// Purpose: Port-level checks of tprf_top
// Assumes: Bound to every tprf_top instance
// Notes: Latency slack covers the pin synchronisers
`timescale 1ns/1ps
module tprf_top_asserts #(
  parameter [23:0] BOOT_ENTRY = 24'h000000
) (
  input wire mclk_i,
  input wire rst_i,
  input wire reset_n_i,
  input wire bit_set_instruction_i,
  input wire bit_clear_instruction_i,
  input wire cpu_status_word_one_wr_i,
  input wire [15:0] cpu_status_word_one_wdata_i,
  input wire tck_i,
  input wire test_reset_i,
  input wire emulation_pin_zero_i,
  input wire external_flag_output_o,
  input wire cpu_halt_o,
  input wire [23:0] pc_o,
  input wire reset_pullup_en_o,
  input wire tdo_o,
  input wire tdo_oe_n_o,
  input wire scan_mode_o,
  input wire emu_port_sel_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Flag and reset
  set_flag_a: assert property (bit_set_instruction_i |=> external_flag_output_o)
    else $error("flag not set after set strobe");
  clear_flag_a: assert property (((bit_clear_instruction_i || cpu_status_word_one_wr_i &&
    !cpu_status_word_one_wdata_i[13]) && !bit_set_instruction_i && !cpu_halt_o ##1 !cpu_halt_o)
    |-> !external_flag_output_o) else $error("flag not cleared");
  flag_reset_a: assert property (cpu_halt_o |-> external_flag_output_o)
    else $error("flag low in reset");
  halt_vector_a: assert property (cpu_halt_o |-> pc_o == 24'hFFFF00)
    else $error("pc not at vector in reset");
  boot_branch_a: assert property ($fell(cpu_halt_o) |-> pc_o == 24'hFFFF00 ##1 pc_o == BOOT_ENTRY)
    else $error("no branch to loader");
  pullup_on_a: assert property (!reset_n_i [*4] |-> reset_pullup_en_o)
    else $error("pull-up off in reset");
  // ==========================================
  // Test port
  tdo_hold_a: assert property ($rose(tck_i) |=> $stable(tdo_o) [*3])
    else $error("tdo moved after rising test clock");
  tdo_idle_a: assert property (!test_reset_i [*8] |-> tdo_oe_n_o)
    else $error("tdo driven in functional mode");
  scan_off_a: assert property (!test_reset_i [*4] |-> !scan_mode_o)
    else $error("scan mode with test reset low");
  emu_latch_a: assert property (($rose(test_reset_i) ##1 $stable(emulation_pin_zero_i) [*6])
    |-> emu_port_sel_o == emulation_pin_zero_i) else $error("emulation pin not latched");
endmodule
bind tprf_top tprf_top_asserts #(.BOOT_ENTRY(BOOT_ENTRY)) u_tprf_top_asserts (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .reset_n_i(reset_n_i),
  .bit_set_instruction_i(bit_set_instruction_i),
  .bit_clear_instruction_i(bit_clear_instruction_i),
  .cpu_status_word_one_wr_i(cpu_status_word_one_wr_i),
  .cpu_status_word_one_wdata_i(cpu_status_word_one_wdata_i),
  .tck_i(tck_i),
  .test_reset_i(test_reset_i),
  .emulation_pin_zero_i(emulation_pin_zero_i),
  .external_flag_output_o(external_flag_output_o),
  .cpu_halt_o(cpu_halt_o),
  .pc_o(pc_o),
  .reset_pullup_en_o(reset_pullup_en_o),
  .tdo_o(tdo_o),
  .tdo_oe_n_o(tdo_oe_n_o),
  .scan_mode_o(scan_mode_o),
  .emu_port_sel_o(emu_port_sel_o)
);

// >>> tb/tprf_tester.sv
// Purpose: Boundary-scan tester at the far side of the test port
// Assumes: Test clock period 320 ns, stopped low between frames
// Notes: Undriven tdo reads as the inverse of its last value
`timescale 1ns/1ps
module tprf_tester (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_n_i
);
  logic last = 1'b0;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // ==========================================
  // One test clock period, tdo taken late in high phase
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #160 tck_o = 1'b1;
    #150 last = tdo_oe_n_i ? ~last : tdo_i;
    tdo = last;
    #10 tck_o = 1'b0;
  endtask
  task automatic move(input logic [15:0] b, input int n);
    logic d;
    #11;
    for (int i = 0; i < n; i++) begin
      step(b[i], 1'b1, d);
    end
  endtask
  task automatic scan(input logic [7:0] din, input int n, output logic [7:0] dout);
    logic b;
    dout = 8'h00;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tdi_o = 1'b1;
  endtask
endmodule

// >>> tb/tprf_top_bench.sv
// Purpose: Self-checking bench of tprf_top
// Assumes: Tester model drives the test clock, mode and data pins; the bench drives test reset and emulation pin zero
// Notes: Checks are taken on the falling clock edge
`timescale 1ns/1ps
module tprf_top_bench;
  logic mclk_i = 1'b0, rst_i = 1'b1, reset_n_i = 1'b1, test_reset_i = 1'b0;
  logic bit_set_instruction_i = 1'b0, bit_clear_instruction_i = 1'b0;
  logic cpu_status_word_one_wr_i = 1'b0, pull_inhibit_register_two_i = 1'b0;
  logic emulation_pin_zero_i = 1'b0;
  logic [15:0] cpu_status_word_one_wdata_i = 16'h0000;
  logic [7:0] scan_capture_i = 8'h3C;
  wire tck_i, tms_i, tdi_i, external_flag_output_o, cpu_halt_o, reset_pullup_en_o;
  wire tdo_o, tdo_oe_n_o, scan_mode_o, emu_port_sel_o;
  wire [15:0] cpu_status_word_one_o;
  wire [23:0] pc_o;
  wire [7:0] scan_update_o;
  wire [3:0] instr_o;
  int n_mismatch = 0, tests_run = 0;
  tprf_top #(.BOOT_ENTRY(24'h012345)) u_tprf_top (
    .mclk_i(mclk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
    .bit_set_instruction_i(bit_set_instruction_i),
    .bit_clear_instruction_i(bit_clear_instruction_i),
    .cpu_status_word_one_wr_i(cpu_status_word_one_wr_i),
    .cpu_status_word_one_wdata_i(cpu_status_word_one_wdata_i),
    .pull_inhibit_register_two_i(pull_inhibit_register_two_i),
    .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .test_reset_i(test_reset_i),
    .emulation_pin_zero_i(emulation_pin_zero_i), .scan_capture_i(scan_capture_i),
    .external_flag_output_o(external_flag_output_o),
    .cpu_status_word_one_o(cpu_status_word_one_o), .cpu_halt_o(cpu_halt_o), .pc_o(pc_o),
    .reset_pullup_en_o(reset_pullup_en_o), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
    .scan_mode_o(scan_mode_o), .emu_port_sel_o(emu_port_sel_o),
    .scan_update_o(scan_update_o), .instr_o(instr_o)
  );
  tprf_tester u_tprf_tester (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o),
    .tdo_oe_n_i(tdo_oe_n_o));
  // ==========================================
  // Helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic op(input logic [2:0] k, input logic [15:0] d, input logic exp);
    @(posedge mclk_i);
    bit_set_instruction_i <= k[0];
    bit_clear_instruction_i <= k[1];
    cpu_status_word_one_wr_i <= k[2];
    cpu_status_word_one_wdata_i <= d;
    @(posedge mclk_i);
    {bit_set_instruction_i, bit_clear_instruction_i, cpu_status_word_one_wr_i} <= 3'b000;
    settle(1);
    chk(external_flag_output_o, exp);
  endtask
  task automatic print_verdict;
    $display("compares=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    int i;
    settle(5);
    chk(cpu_halt_o, 24'h0);
    op(3'b010, 16'h0000, 1'b0);
    @(posedge mclk_i);
    pull_inhibit_register_two_i <= 1'b1;
    reset_n_i <= 1'b0;
    settle(5);
    chk(external_flag_output_o, 24'h1);
    chk(cpu_halt_o, 24'h1);
    chk(pc_o, 24'hFFFF00);
    chk(cpu_status_word_one_o, 24'h2000);
    chk(reset_pullup_en_o, 24'h1);
    op(3'b010, 16'h0000, 1'b1);
    @(posedge mclk_i);
    reset_n_i <= 1'b1;
    i = 0;
    while (cpu_halt_o !== 1'b0 && i < 10) begin
      settle(1);
      i++;
    end
    chk(pc_o, 24'hFFFF00);
    settle(1);
    chk(pc_o, 24'h012345);
    chk(reset_pullup_en_o, 24'h0);
    @(posedge mclk_i);
    pull_inhibit_register_two_i <= 1'b0;
    settle(2);
    chk(reset_pullup_en_o, 24'h1);
    $display("t_reset done");
  endtask
  task automatic t_flag;
    op(3'b001, 16'h0000, 1'b1);
    op(3'b010, 16'h0000, 1'b0);
    op(3'b001, 16'h0000, 1'b1);
    op(3'b100, 16'h2001, 1'b1);
    chk(cpu_status_word_one_o, 24'h2001);
    op(3'b100, 16'h0001, 1'b0);
    op(3'b011, 16'h0000, 1'b1);
    $display("t_flag done");
  endtask
  task automatic t_mode;
    u_tprf_tester.move(16'h00DF, 10);
    settle(6);
    chk(tdo_oe_n_o, 24'h1);
    chk(instr_o, 24'hF);
    @(posedge mclk_i);
    emulation_pin_zero_i <= 1'b1;
    test_reset_i <= 1'b1;
    settle(8);
    chk(emu_port_sel_o, 24'h1);
    chk(scan_mode_o, 24'h0);
    u_tprf_tester.move(16'h00DF, 10);
    settle(6);
    chk(tdo_oe_n_o, 24'h1);
    @(posedge mclk_i);
    emulation_pin_zero_i <= 1'b0;
    test_reset_i <= 1'b0;
    settle(8);
    @(posedge mclk_i);
    test_reset_i <= 1'b1;
    settle(8);
    chk(emu_port_sel_o, 24'h0);
    chk(scan_mode_o, 24'h1);
    $display("t_mode done");
  endtask
  task automatic t_scan;
    logic [7:0] d;
    u_tprf_tester.move(16'h00DF, 10);
    u_tprf_tester.scan(8'h00, 4, d);
    chk(d, 24'h01);
    u_tprf_tester.move(16'h0005, 5);
    settle(6);
    chk(instr_o, 24'h0);
    chk(tdo_oe_n_o, 24'h0);
    u_tprf_tester.scan(8'hA5, 8, d);
    chk(d, 24'h3C);
    u_tprf_tester.move(16'h0001, 2);
    settle(6);
    chk(scan_update_o, 24'hA5);
    chk(tdo_oe_n_o, 24'h1);
    $display("t_scan done");
  endtask
  // ==========================================
  // Clock, sequence and watchdog
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    settle(1);
    chk(external_flag_output_o, 24'h1);
    chk(instr_o, 24'hF);
    chk(tdo_oe_n_o, 24'h1);
    @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_flag();
    t_mode();
    t_scan();
    print_verdict();
  end
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule
